//--- apsf_pkg.sv
// Behaviour
// R1 - Device stays asleep while the sleep_exit bit is zero; setting it wakes it.
// R2 - With broadcast_address_enable set, answer at fixed address 1001100 as well.
// R3 - Quick-charge code selects 3.5, 10, 50 or 100 ms charge time.
// R4 - analog_supply_source_sel set picks on-chip regulator, clear picks external rail.
// R5 - Software writes zero into reserved sleep register bits 6 to 5 and 1.
// R6 - Protocol field: 0 multiplexed slots, 1 I2S, 2 left justified, 3 reserved.
// R7 - Slot length codes 0 to 3 give 16, 20, 24, 32 bits; reset code 3.
// R8 - Polarity bits keep standard polarity when clear, invert it when set.
// R9 - Transmit edge bit moves the data launch half a bit-clock cycle later; with bclk_inv clear the code launches on the rising edge, half a cycle earlier.
// R10 - Unused bit-clock cycles drive zero, or high impedance when fill bit set.
// R11 - Page register at offset 0 selects page; these registers live on page 0.
// R12 - Port setting changes apply only at frame start or while powered down.
package apsf_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [7:0] PAGE_SELECT_OFS   = 8'h00;
    localparam logic [7:0] SLEEP_SUPPLY_OFS  = 8'h02;
    localparam logic [7:0] PORT_FORMAT_OFS   = 8'h07;
    localparam logic [7:0] PAGE_ZERO         = 8'h00;
    localparam logic [7:0] PAGE_SELECT_RST   = 8'h00;
    localparam logic [7:0] SLEEP_SUPPLY_RST  = 8'h00;
    localparam logic [7:0] PORT_FORMAT_RST   = 8'h30;
    localparam logic [7:0] SLEEP_WR_MASK     = 8'hFD;  // Bit 1 is read-only zero.
    localparam int         SLEEP_EXIT_BIT    = 0;
    localparam int         BCAST_EN_BIT      = 2;
    localparam int         QCHG_LSB          = 3;
    localparam int         ASRC_SEL_BIT      = 7;

    // ----------------------------------------------------------------
    // Control bus addressing
    // ----------------------------------------------------------------
    localparam logic [6:0] BROADCAST_ADDR    = 7'h4C;
    localparam logic [6:0] DEV_ADDR_DEFAULT  = 7'h2A;  // Arbitrary value.
    localparam logic [3:0] BITS_PER_BYTE     = 4'h8;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int unsigned CLK_HZ           = 10_000_000;
    localparam int unsigned CYC_PER_US       = CLK_HZ / 1_000_000;
    localparam int unsigned QCHG0_TIME_US    = 3500;
    localparam int unsigned QCHG1_TIME_US    = 10000;
    localparam int unsigned QCHG2_TIME_US    = 50000;
    localparam int unsigned QCHG3_TIME_US    = 100000;
    localparam int unsigned QCHG0_CYC        = QCHG0_TIME_US * CYC_PER_US;
    localparam int unsigned QCHG1_CYC        = QCHG1_TIME_US * CYC_PER_US;
    localparam int unsigned QCHG2_CYC        = QCHG2_TIME_US * CYC_PER_US;
    localparam int unsigned QCHG3_CYC        = QCHG3_TIME_US * CYC_PER_US;
    localparam int          QCHG_W           = 20;

    // ----------------------------------------------------------------
    // Audio port
    // ----------------------------------------------------------------
    localparam int         SLOTS             = 4;
    localparam int         SAMPLE_W          = 32;
    localparam logic [2:0] SLOT_NONE         = 3'h4;
    localparam logic [5:0] SLOT_BITS_16      = 6'h10;
    localparam logic [5:0] SLOT_BITS_20      = 6'h14;
    localparam logic [5:0] SLOT_BITS_24      = 6'h18;
    localparam logic [5:0] SLOT_BITS_32      = 6'h20;
    localparam logic [5:0] MSB_INDEX         = 6'h1F;

    typedef enum logic [1:0] {
        PROTO_TDM  = 2'h0,
        PROTO_I2S  = 2'h1,
        PROTO_LJ   = 2'h2,
        PROTO_RSVD = 2'h3
    } apsf_proto_type;

    // Field layout follows the format register bit for bit.
    typedef struct packed {
        apsf_proto_type proto;
        logic [1:0]     slot_len;
        logic           fs_inv;
        logic           bclk_inv;
        logic           tx_edge;
        logic           fill_hiz;
    } apsf_port_cfg_type;

    typedef struct packed {
        logic data;
        logic oe;
    } apsf_pin_type;

    typedef enum logic [6:0] {
        ST_IDLE  = 7'h01,
        ST_ADDR  = 7'h02,
        ST_ACK_A = 7'h04,
        ST_WR    = 7'h08,
        ST_ACK_W = 7'h10,
        ST_RD    = 7'h20,
        ST_ACK_R = 7'h40
    } apsf_bus_state_type;

    function automatic logic [5:0] apsf_slot_bits(input logic [1:0] code);
        unique case (code)
            2'h0:    apsf_slot_bits = SLOT_BITS_16;
            2'h1:    apsf_slot_bits = SLOT_BITS_20;
            2'h2:    apsf_slot_bits = SLOT_BITS_24;
            default: apsf_slot_bits = SLOT_BITS_32;
        endcase
    endfunction : apsf_slot_bits

endpackage : apsf_pkg

//--- apsf_top.sv
`timescale 1ns/1ps
module apsf_top #(
    parameter logic [6:0]  DEV_ADDR  = apsf_pkg::DEV_ADDR_DEFAULT,
    parameter int unsigned QCHG0_CYC = apsf_pkg::QCHG0_CYC,
    parameter int unsigned QCHG1_CYC = apsf_pkg::QCHG1_CYC,
    parameter int unsigned QCHG2_CYC = apsf_pkg::QCHG2_CYC,
    parameter int unsigned QCHG3_CYC = apsf_pkg::QCHG3_CYC
) (
    input  wire logic                                          ref_clk_i,    // System clock.
    input  wire logic                                          nrst_i,       // Async reset, low.
    input  wire logic                                          scl_i,        // Control bus clock.
    input  wire logic                                          sda_i,        // Control bus data in.
    output logic                                               sda_o,        // Data out, always 0.
    output logic                                               sda_oe_o,     // Pulls data low.
    input  wire logic                                          bit_clock_i,  // Audio bit clock.
    input  wire logic                                          frame_sync_i, // Frame sync pin.
    input  wire logic [apsf_pkg::SLOTS-1:0][apsf_pkg::SAMPLE_W-1:0] ch_data_i, // Samples.
    output logic                                               data_pri_o,   // Primary data.
    output logic                                               data_pri_oe_o,// Primary enable.
    output logic                                               data_sec_o,   // Secondary data.
    output logic                                               data_sec_oe_o,// Secondary enable.
    output logic                                               sleep_o,      // Device asleep.
    output logic                                               rail_int_o,   // Internal rail.
    output logic                                               qchg_active_o // Charging.
);
    import apsf_pkg::*;

    // ----------------------------------------------------------------
    // Reset release and pin synchronisers
    // ----------------------------------------------------------------
    logic rst_meta_q, rst_n_q, lrst_meta_q, lrst_n_q;
    logic scl_m_q, scl_s_q, scl_p_q, sda_m_q, sda_s_q, sda_p_q;

    // Both domains assert reset at once but release it on their own clock.
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rst_meta_q <= 1'b0;
            rst_n_q    <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q    <= rst_meta_q;
        end
    end

    always_ff @(posedge bit_clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            lrst_meta_q <= 1'b0;
            lrst_n_q    <= 1'b0;
        end else begin
            lrst_meta_q <= 1'b1;
            lrst_n_q    <= lrst_meta_q;
        end
    end

    // Only the second and third stages feed the edge detectors.
    always_ff @(posedge ref_clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            {scl_m_q, scl_s_q, scl_p_q} <= 3'h7;
            {sda_m_q, sda_s_q, sda_p_q} <= 3'h7;
        end else begin
            {scl_m_q, scl_s_q, scl_p_q} <= {scl_i, scl_m_q, scl_s_q};
            {sda_m_q, sda_s_q, sda_p_q} <= {sda_i, sda_m_q, sda_s_q};
        end
    end

    logic scl_rise, scl_fall, bus_start, bus_stop;
    assign scl_rise  = scl_s_q & ~scl_p_q;
    assign scl_fall  = ~scl_s_q & scl_p_q;
    assign bus_start = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
    assign bus_stop  = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;

    // ----------------------------------------------------------------
    // Control bus slave
    // ----------------------------------------------------------------
    apsf_bus_state_type st_q, st_d;
    logic [3:0] cnt_q, cnt_d;
    logic [7:0] sh_q, sh_d, ptr_q, ptr_d, wadr_q, wadr_d, wdat_q, wdat_d, rd_data;
    logic       rw_q, rw_d, first_q, first_d, oe_q, oe_d, wr_q, wr_d, addr_hit;
    logic [7:0] page_q, page_d, sleep_q, sleep_d, fmt_q, fmt_d;

    assign addr_hit = (sh_q[7:1] == DEV_ADDR) ||
                      (sleep_q[BCAST_EN_BIT] && (sh_q[7:1] == BROADCAST_ADDR)); // see R2

    // Byte engine: pointer byte first, then data with auto-increment.
    always_comb begin
        st_d    = st_q;
        cnt_d   = cnt_q;
        sh_d    = sh_q;
        ptr_d   = ptr_q;
        rw_d    = rw_q;
        first_d = first_q;
        oe_d    = oe_q;
        wr_d    = 1'b0;
        wadr_d  = wadr_q;
        wdat_d  = wdat_q;
        if (bus_start) begin
            st_d  = ST_ADDR;
            cnt_d = 4'h0;
            oe_d  = 1'b0;
        end else if (bus_stop) begin
            st_d = ST_IDLE;
            oe_d = 1'b0;
        end else begin
            unique case (st_q)
                ST_IDLE: begin
                    oe_d = 1'b0;
                end
                ST_ADDR, ST_WR: begin
                    if (scl_rise) begin
                        sh_d  = {sh_q[6:0], sda_s_q};
                        cnt_d = cnt_q + 4'h1;
                    end else if (scl_fall && cnt_q == BITS_PER_BYTE) begin
                        if (st_q == ST_WR) begin
                            st_d    = ST_ACK_W;
                            oe_d    = 1'b1;
                            first_d = 1'b0;
                            if (first_q) begin
                                ptr_d = sh_q;
                            end else begin
                                wr_d   = 1'b1;
                                wadr_d = ptr_q;
                                wdat_d = sh_q;
                                ptr_d  = ptr_q + 8'h01;
                            end
                        end else if (addr_hit) begin
                            st_d = ST_ACK_A;
                            oe_d = 1'b1;
                            rw_d = sh_q[0];
                        end else begin
                            st_d = ST_IDLE;
                        end
                    end
                end
                ST_ACK_A, ST_ACK_W: begin
                    if (scl_fall) begin
                        cnt_d = 4'h0;
                        if (st_q == ST_ACK_A && rw_q) begin
                            st_d = ST_RD;
                            sh_d = rd_data;
                            oe_d = ~rd_data[7];
                        end else begin
                            st_d    = ST_WR;
                            oe_d    = 1'b0;
                            first_d = (st_q == ST_ACK_A);
                        end
                    end
                end
                ST_RD: begin
                    if (scl_rise) begin
                        cnt_d = cnt_q + 4'h1;
                    end else if (scl_fall) begin
                        if (cnt_q == BITS_PER_BYTE) begin
                            st_d  = ST_ACK_R;
                            oe_d  = 1'b0;
                            ptr_d = ptr_q + 8'h01;
                        end else begin
                            sh_d = {sh_q[6:0], 1'b0};
                            oe_d = ~sh_q[6];
                        end
                    end
                end
                ST_ACK_R: begin
                    if (scl_rise && sda_s_q) begin
                        st_d = ST_IDLE;
                    end else if (scl_fall) begin
                        st_d  = ST_RD;
                        cnt_d = 4'h0;
                        sh_d  = rd_data;
                        oe_d  = ~rd_data[7];
                    end
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            st_q    <= ST_IDLE;
            cnt_q   <= 4'h0;
            sh_q    <= 8'h00;
            ptr_q   <= 8'h00;
            rw_q    <= 1'b0;
            first_q <= 1'b0;
            oe_q    <= 1'b0;
            wr_q    <= 1'b0;
            wadr_q  <= 8'h00;
            wdat_q  <= 8'h00;
        end else begin
            st_q    <= st_d;
            cnt_q   <= cnt_d;
            sh_q    <= sh_d;
            ptr_q   <= ptr_d;
            rw_q    <= rw_d;
            first_q <= first_d;
            oe_q    <= oe_d;
            wr_q    <= wr_d;
            wadr_q  <= wadr_d;
            wdat_q  <= wdat_d;
        end
    end

    assign sda_o    = 1'b0;
    assign sda_oe_o = oe_q;

    // ----------------------------------------------------------------
    // Registers and readback
    // ----------------------------------------------------------------
    // The page register answers on every page so software can always go back.
    always_comb begin
        page_d  = page_q;
        sleep_d = sleep_q;
        fmt_d   = fmt_q;
        rd_data = 8'h00;
        if (wr_q && wadr_q == PAGE_SELECT_OFS) begin
            page_d = wdat_q;                                            // see R11
        end else if (wr_q && page_q == PAGE_ZERO) begin                 // see R11
            if (wadr_q == SLEEP_SUPPLY_OFS) begin
                sleep_d = wdat_q & SLEEP_WR_MASK;
            end else if (wadr_q == PORT_FORMAT_OFS) begin
                fmt_d = wdat_q;
            end
        end
        if (ptr_q == PAGE_SELECT_OFS) begin
            rd_data = page_q;
        end else if (page_q == PAGE_ZERO && ptr_q == SLEEP_SUPPLY_OFS) begin
            rd_data = sleep_q;
        end else if (page_q == PAGE_ZERO && ptr_q == PORT_FORMAT_OFS) begin
            rd_data = fmt_q;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            page_q     <= PAGE_SELECT_RST;
            sleep_q    <= SLEEP_SUPPLY_RST;
            fmt_q      <= PORT_FORMAT_RST;                              // see R7
            sleep_o    <= 1'b1;
            rail_int_o <= 1'b0;
        end else begin
            page_q     <= page_d;
            sleep_q    <= sleep_d;
            fmt_q      <= fmt_d;
            sleep_o    <= ~sleep_d[SLEEP_EXIT_BIT];                     // see R1
            rail_int_o <= sleep_d[ASRC_SEL_BIT];                        // see R4
        end
    end

    // ----------------------------------------------------------------
    // Reference quick charge
    // ----------------------------------------------------------------
    logic [QCHG_W-1:0] qc_q, qc_d, qc_load;
    logic              awake_p_q;

    // The charge window starts on each wake and is abandoned on sleep.
    always_comb begin
        unique case (sleep_q[QCHG_LSB +: 2])                           // see R3
            2'h0:    qc_load = QCHG_W'(QCHG0_CYC);
            2'h1:    qc_load = QCHG_W'(QCHG1_CYC);
            2'h2:    qc_load = QCHG_W'(QCHG2_CYC);
            default: qc_load = QCHG_W'(QCHG3_CYC);
        endcase
        qc_d = qc_q;
        if (!sleep_q[SLEEP_EXIT_BIT]) begin
            qc_d = '0;
        end else if (!awake_p_q) begin
            qc_d = qc_load;
        end else if (qc_q != '0) begin
            qc_d = qc_q - QCHG_W'(1);
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            qc_q          <= '0;
            awake_p_q     <= 1'b0;
            qchg_active_o <= 1'b0;
        end else begin
            qc_q          <= qc_d;
            awake_p_q     <= sleep_q[SLEEP_EXIT_BIT];
            qchg_active_o <= (qc_d != '0);
        end
    end

    // ----------------------------------------------------------------
    // Settings handshake into the bit-clock domain
    // ----------------------------------------------------------------
    logic [8:0] shadow_q, shadow_d, pend_cfg_q;
    logic       req_q, req_d, ack_m_q, ack_s_q, req_m_q, req_s_q, req_p_q, pend_q;

    // The shadow only changes after the far side has acknowledged it.
    always_comb begin
        shadow_d = shadow_q;
        req_d    = req_q;
        if (ack_s_q == req_q && shadow_q != {fmt_q, sleep_q[SLEEP_EXIT_BIT]}) begin
            shadow_d = {fmt_q, sleep_q[SLEEP_EXIT_BIT]};
            req_d    = ~req_q;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            shadow_q <= {PORT_FORMAT_RST, 1'b0};
            req_q    <= 1'b0;
            ack_m_q  <= 1'b0;
            ack_s_q  <= 1'b0;
        end else begin
            shadow_q <= shadow_d;
            req_q    <= req_d;
            ack_m_q  <= req_p_q;
            ack_s_q  <= ack_m_q;
        end
    end

    // ----------------------------------------------------------------
    // Serial transmitter on the bit clock
    // ----------------------------------------------------------------
    apsf_port_cfg_type act_q, act_d;
    logic       awake_q, awake_d, fs_p_q, run_q, run_d, right_q, right_d;
    logic       fs_s, fs_rise, fs_fall, frm, half, take, valid;
    logic [5:0] bit_q, bit_d, slen;
    logic [2:0] slot_q, slot_d;
    logic [1:0] ch_pri;
    logic [SLOTS-1:0][SAMPLE_W-1:0] smp_q, smp_d;
    apsf_pin_type pri_q, pri_d, sec_q, sec_d, pri_n_q, sec_n_q;

    assign fs_s    = frame_sync_i ^ act_q.fs_inv;                       // see R8
    assign fs_rise = fs_s & ~fs_p_q;
    assign fs_fall = ~fs_s & fs_p_q;
    assign frm     = (act_q.proto == PROTO_I2S) ? fs_fall : fs_rise;
    assign half    = (act_q.proto != PROTO_TDM) &&
                     ((act_q.proto == PROTO_I2S) ? fs_rise : fs_fall);
    assign slen    = apsf_slot_bits(act_q.slot_len);                    // see R7

    // Slot counting and data selection for the next launched bit.
    always_comb begin
        take    = pend_q && (frm || !awake_q);                          // see R12
        act_d   = take ? apsf_port_cfg_type'(pend_cfg_q[8:1]) : act_q;
        awake_d = take ? pend_cfg_q[0] : awake_q;
        bit_d   = bit_q;
        slot_d  = slot_q;
        right_d = right_q;
        run_d   = run_q && awake_q;
        smp_d   = frm ? ch_data_i : smp_q;
        if (frm || half) begin
            bit_d   = 6'h00;
            slot_d  = 3'h0;
            right_d = half;
            run_d   = awake_q;
        end else if (run_q && slot_q != SLOT_NONE) begin
            bit_d  = (bit_q == slen - 6'h01) ? 6'h00 : bit_q + 6'h01;
            slot_d = (bit_q == slen - 6'h01) ? slot_q + 3'h1 : slot_q;
        end
        ch_pri = (act_q.proto == PROTO_TDM) ? slot_d[1:0] : {1'b0, right_d};
        valid  = run_d && awake_q && (act_q.proto != PROTO_RSVD) &&     // see R6
                 ((act_q.proto == PROTO_TDM) ? (slot_d != SLOT_NONE) : (slot_d == 3'h0));
        pri_d  = '{data: smp_d[ch_pri][5'(MSB_INDEX - bit_d)], oe: 1'b1};
        sec_d  = '{data: smp_d[{1'b1, right_d}][5'(MSB_INDEX - bit_d)], oe: 1'b1};
        if (!valid || !awake_q) begin
            pri_d = '{data: 1'b0, oe: awake_q && !act_q.fill_hiz};      // see R10
        end
        if (!valid || !awake_q || act_q.proto == PROTO_TDM) begin
            sec_d = '{data: 1'b0, oe: awake_q && !act_q.fill_hiz};      // see R10
        end
    end

    always_ff @(posedge bit_clock_i or negedge lrst_n_q) begin
        if (!lrst_n_q) begin
            act_q      <= apsf_port_cfg_type'(PORT_FORMAT_RST);
            awake_q    <= 1'b0;
            fs_p_q     <= 1'b0;
            run_q      <= 1'b0;
            right_q    <= 1'b0;
            bit_q      <= 6'h00;
            slot_q     <= SLOT_NONE;
            smp_q      <= '0;
            pri_q      <= '0;
            sec_q      <= '0;
            req_m_q    <= 1'b0;
            req_s_q    <= 1'b0;
            req_p_q    <= 1'b0;
            pend_q     <= 1'b0;
            pend_cfg_q <= {PORT_FORMAT_RST, 1'b0};
        end else begin
            act_q      <= act_d;
            awake_q    <= awake_d;
            fs_p_q     <= fs_s;
            run_q      <= run_d;
            right_q    <= right_d;
            bit_q      <= bit_d;
            slot_q     <= slot_d;
            smp_q      <= smp_d;
            pri_q      <= pri_d;
            sec_q      <= sec_d;
            req_m_q    <= req_q;
            req_s_q    <= req_m_q;
            req_p_q    <= req_s_q;
            pend_q     <= (req_s_q ^ req_p_q) | (pend_q & ~take);
            pend_cfg_q <= (req_s_q ^ req_p_q) ? shadow_q : pend_cfg_q;
        end
    end

    // Falling-edge copy gives the half-cycle launch choice.
    always_ff @(negedge bit_clock_i or negedge lrst_n_q) begin
        if (!lrst_n_q) begin
            pri_n_q <= '0;
            sec_n_q <= '0;
        end else begin
            pri_n_q <= pri_q;
            sec_n_q <= sec_q;
        end
    end

    // Standard launch is on the falling edge; each inversion toggles it.
    logic launch_rise;
    assign launch_rise   = act_q.bclk_inv ^ act_q.tx_edge;              // see R8 see R9
    assign data_pri_o    = launch_rise ? pri_q.data : pri_n_q.data;
    assign data_pri_oe_o = launch_rise ? pri_q.oe : pri_n_q.oe;
    assign data_sec_o    = launch_rise ? sec_q.data : sec_n_q.data;
    assign data_sec_oe_o = launch_rise ? sec_q.oe : sec_n_q.oe;

endmodule : apsf_top

//--- apsf_chk.sv
`timescale 1ns/1ps
// Checks at the top ports.
module apsf_chk #(parameter int unsigned QCHG3_CYC = 80) (
    input wire logic ref_clk_i, nrst_i, sda_o, sda_oe_o, data_pri_oe_o, data_sec_oe_o,
    input wire logic sleep_o, rail_int_o, qchg_active_o);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!nrst_i);
    int unsigned run_q;
    // Charge length; an endless charge is caught.
    always_ff @(posedge ref_clk_i) run_q <= qchg_active_o ? run_q + 1 : 0;
    sequence s_ack; $past(sda_oe_o) || $past(sda_oe_o, 2) || $past(sda_oe_o, 3); endsequence
    a_wake_charge: assert property ($fell(sleep_o) |-> ##[0:4] qchg_active_o) else $error("c1");
    a_charge_len: assert property (run_q <= QCHG3_CYC + 4) else $error("c2");
    a_charge_awake: assert property ($rose(qchg_active_o) |-> !sleep_o) else $error("c3");
    a_sleep_quiet: assert property (sleep_o [*8] ##1 sleep_o [*8] |->
        !data_pri_oe_o && !data_sec_oe_o) else $error("c4");
    a_wake_cause: assert property ($fell(sleep_o) |-> s_ack) else $error("c5");
    a_sleep_cause: assert property ($rose(sleep_o) |-> s_ack) else $error("c6");
    a_rail_cause: assert property ($changed(rail_int_o) |-> s_ack) else $error("c7");
    a_pull_only: assert property (sda_o == 1'b0) else $error("c8");
endmodule : apsf_chk
bind apsf_top apsf_chk #(.QCHG3_CYC(QCHG3_CYC)) u_apsf_chk (.ref_clk_i, .nrst_i, .sda_o,
    .sda_oe_o, .data_pri_oe_o, .data_sec_oe_o, .sleep_o, .rail_int_o, .qchg_active_o);

//--- apsf_host.sv
`timescale 1ns/1ps
// Host end of the audio link.
module apsf_host (output logic bclk_o, fs_o, logic [31:0] word_o, drv_o,
    logic [7:0] frames_o, input wire logic pri_i, pri_oe_i);
    logic [5:0] cnt_q = 6'h00;
    logic [31:0] sh_q, oe_q;
    initial {bclk_o, fs_o, frames_o} = 10'h100;
    always #7.5 bclk_o = ~bclk_o;
    // Frame sync moves on falling edges.
    always @(negedge bclk_o) begin
        cnt_q <= cnt_q + 6'h01;
        fs_o <= (cnt_q >= 6'h1F) && (cnt_q != 6'h3F);
    end
    // An undriven bit reads inverted, never as a lucky match.
    always @(posedge bclk_o) begin
        if (cnt_q != 6'h00 && cnt_q <= 6'h20) begin
            sh_q <= {sh_q[30:0], pri_oe_i ? pri_i : ~sh_q[0]};
            oe_q <= {oe_q[30:0], pri_oe_i};
        end
        if (cnt_q == 6'h21) begin
            {word_o, drv_o} <= {sh_q, oe_q};
            frames_o <= frames_o + 8'h01;
        end
    end
endmodule : apsf_host

//--- tb_apsf_top.sv
`timescale 1ns/1ps
module tb_apsf_top;
    import apsf_pkg::*;
    localparam logic [6:0] DA = DEV_ADDR_DEFAULT;
    logic ref_clk_i = 1'b0, nrst_i = 1'b0, scl_i = 1'b1, sda_m = 1'b1, ack, bclk, fs, pri, pe;
    logic sda_o, sda_oe_o, sleep_o, rail_o;
    logic [7:0] frames, rd_v;
    logic [31:0] word, drv;
    int bad_count = 0, cmp_count = 0;
    wire logic sda_w = sda_m & ~sda_oe_o;  // Pulled-up open drain.
    logic [SLOTS-1:0][SAMPLE_W-1:0] ch = {SLOTS{32'hC3D2E1F0}};
    logic [7:0] cfg [3] = '{8'h40, 8'h41, 8'hC0};
    logic [31:0] ew [3] = '{32'hC3D20000, 32'hC3D20000, 32'h0}, ed [3] = '{'1, 32'hFFFF0000, '1};
    always #50 ref_clk_i = ~ref_clk_i;
    apsf_top #(.QCHG0_CYC(20), .QCHG1_CYC(40), .QCHG2_CYC(60), .QCHG3_CYC(80)) u_apsf_top (
        .ref_clk_i, .nrst_i, .scl_i, .sda_i(sda_w), .sda_o, .sda_oe_o, .bit_clock_i(bclk),
        .frame_sync_i(fs), .ch_data_i(ch), .data_pri_o(pri), .data_pri_oe_o(pe), .data_sec_o(),
        .data_sec_oe_o(), .sleep_o, .rail_int_o(rail_o), .qchg_active_o());
    apsf_host u_apsf_host (.bclk_o(bclk), .fs_o(fs), .word_o(word), .drv_o(drv),
        .frames_o(frames), .pri_i(pri), .pri_oe_i(pe));
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk_i);
    endtask : tick
    // The bus clock is high for five cycles and low for ten.
    task automatic bit_io(input logic b, output logic r);
        sda_m <= b;
        tick(5);
        scl_i <= 1'b1;
        tick(5);
        r = sda_w;
        scl_i <= 1'b0;
        tick(5);
    endtask : bit_io
    task automatic frame(input logic s);
        sda_m <= s;
        tick(5);
        scl_i <= 1'b1;
        tick(5);
        sda_m <= !s;
        tick(5);
        if (s) scl_i <= 1'b0;
        tick(5);
    endtask : frame
    task automatic byte_io(input logic [7:0] b, output logic [7:0] r, logic nak);
        for (int i = 7; i >= 0; i--) bit_io(b[i], r[i]);
        bit_io(1'b1, nak);
    endtask : byte_io
    task automatic xfer(input logic [6:0] a, logic [7:0] o, d, logic rd);
        logic [7:0] r;
        logic n;
        frame(1'b1);
        byte_io({a, 1'b0}, r, n);
        ack = !n;
        byte_io(o, r, n);
        if (rd) begin
            frame(1'b1);
            byte_io({a, 1'b1}, r, n);
            byte_io(8'hFF, rd_v, n);
        end else begin
            byte_io(d, r, n);
        end
        frame(1'b0);
    endtask : xfer
    task automatic chk(input string s, logic [31:0] e, g);
        cmp_count++;
        if (g !== e) begin
            bad_count++;
            $display("BAD %s exp %h got %h", s, e, g);
        end
    endtask : chk
    task automatic end_sim();
        $display("compares %0d bad %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : end_sim
    // Settings land at a frame start; the third frame is clean.
    task automatic wait_fr();
        logic [7:0] f0;
        int k;
        f0 = frames;
        for (k = 0; k < 99 && 8'(frames - f0) < 8'h03; k++) tick(1);
        if (k == 99) begin
            chk("frames", 32'h3, 32'(8'(frames - f0)));
            end_sim();
        end
    endtask : wait_fr
    initial begin
        tick(12);
        nrst_i <= 1'b1;
        tick(8);
        xfer(DA, 8'h02, 8'h00, 1'b1);
        chk("sleep", 8'h00, rd_v);
        chk("asleep", 1'b1, sleep_o);
        xfer(BROADCAST_ADDR, 8'h07, 8'h00, 1'b1);
        chk("bcast ack", 1'b0, ack);
        xfer(DA, 8'h07, 8'h00, 1'b1);
        chk("format", 8'h30, rd_v);
        $display("reset done");
        xfer(DA, 8'h02, 8'h85, 1'b0);
        xfer(BROADCAST_ADDR, 8'h02, 8'h00, 1'b1);
        chk("bcast read", 8'h85, rd_v);
        chk("wake rail", 2'b01, {sleep_o, rail_o});
        $display("wake done");
        foreach (cfg[i]) begin
            xfer(DA, 8'h07, cfg[i], 1'b0);
            wait_fr();
            chk("word", ew[i], word & drv);
            chk("driven", ed[i], drv);
        end
        $display("format done");
        xfer(DA, 8'h00, 8'h01, 1'b0);
        xfer(DA, 8'h07, 8'h70, 1'b0);
        xfer(DA, 8'h00, 8'h00, 1'b0);
        xfer(DA, 8'h07, 8'h00, 1'b1);
        chk("page guard", 8'hC0, rd_v);
        xfer(DA, 8'h02, 8'h00, 1'b0);
        wait_fr();
        chk("quiet", 32'h0, drv);
        $display("page sleep done");
        end_sim();
    end
endmodule : tb_apsf_top
